// >>> verilog/pic_pkg.sv
// package: register map, reset values and command codes of the secondary
// interrupt controller and trigger-mode registers.
// assumes byte-wide i/o ports addressed with a 16-bit port number.
package pic_pkg;

    // ************************************************************
    // port numbers
    // ************************************************************
    localparam logic [15:0] PORT_CMD_STATUS = 16'h00A0;
    localparam logic [15:0] PORT_LINE_MASK = 16'h00A1;
    localparam logic [15:0] PORT_PRI_TRIG = 16'h04D0;
    localparam logic [15:0] PORT_SEC_TRIG = 16'h04D1;

    // ************************************************************
    // reset values and fixed bits
    // ************************************************************
    localparam logic [7:0] TRIG_RESET = 8'h00;
    localparam logic [7:0] PRI_TRIG_FIXED = 8'h07; // lines 0..2
    localparam logic [7:0] SEC_TRIG_FIXED = 8'h21; // lines 8 and 13
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] ISR_RESET = 8'h00;
    localparam logic [4:0] VEC_BASE_RESET = 5'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'hFF;

    // ************************************************************
    // command word fields
    // ************************************************************
    localparam int INIT_BIT = 4;          // set: first init word
    localparam int INIT_MODE_BIT = 0;     // first init word: mode word follows
    localparam int INIT_SINGLE_BIT = 1;   // first init word: no cascade word
    localparam logic [1:0] OP_SEL_CODE = 2'h1; // bits 4:3 of select command
    localparam logic [1:0] OP_EOI_CODE = 2'h0; // bits 4:3 of end-of-service
    localparam int SEL_VALID_BIT = 1;
    localparam int SEL_ISR_BIT = 0;
    localparam logic [2:0] EOI_NONSPEC = 3'h1;
    localparam logic [2:0] EOI_SPEC = 3'h3;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {INIT_RUN, INIT_VEC, INIT_CAS, INIT_MODE} init_e;

endpackage

// >>> verilog/line_sense.sv
// holds the request latch of each interrupt line, edge or level sensed.
// assumes request inputs synchronous to ref_clk_i.
`timescale 1ns/10ps
module line_sense #(
    parameter int LINES = 16
) (
    input wire logic ref_clk_i,               // system clock
    input wire logic reset_n_i,               // sync reset, active low
    input wire logic [LINES-1:0] line_i,      // request inputs
    input wire logic [LINES-1:0] level_i,     // 1 level, 0 edge
    input wire logic [LINES-1:0] ack_i,       // clear edge latch
    output logic [LINES-1:0] req_o            // latched requests
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [LINES-1:0] prev;
        logic [LINES-1:0] req;
    } sense_s;

    sense_s s;
    sense_s next_s;
    logic [LINES-1:0] rise;

    if (LINES < 1)
    begin : g_check
        $error("line_sense needs at least one line");
    end

    // rising edges and latch update, a new edge beats an acknowledge
    always_comb
    begin
        rise = line_i & ~s.prev;
        next_s.prev = line_i;
        next_s.req = (level_i & line_i) | (~level_i & ((s.req & ~ack_i) | rise));
    end

    // state register
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign req_o = s.req;

    // ************************************************************
    // checks
    // ************************************************************
    property p_level_follows;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        1'b1 |=> ((req_o ^ $past(line_i)) & $past(level_i)) == '0;
    endproperty
    a_level_follows: assert property (p_level_follows)
        else $error("level line request does not follow input");

    property p_edge_latch;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        1'b1 |=> (~req_o & $past(rise) & ~$past(level_i)) == '0;
    endproperty
    a_edge_latch: assert property (p_edge_latch)
        else $error("rising edge not latched");

endmodule

// >>> verilog/slave_pic_regs.sv
// secondary interrupt controller for lines 8..15 with its mask, plus the
// two trigger-mode registers for lines 0..15, on byte-wide i/o ports.
// assumes single-cycle read and write strobes with a 16-bit port number.
// Contract
// - status port read returns pending or in-service per last selection
// - command 0Ah selects pending view, 0Bh selects in-service view
// - selection persists across reads, no need to resend it
// - writes to command port are init and operation commands
// - mask bit n blocks line 8+n when 1, passes it when 0
// - primary trigger bits per line 0..7, 1 level, reset zero
// - primary trigger bits 0..2 are read-only
// - secondary trigger bits per line 8..15, 1 level, reset zero
// - secondary trigger bits 0 and 5 are read-only
`timescale 1ns/10ps
module slave_pic_regs #(
    parameter int ADDR_W = 16
) (
    input wire logic ref_clk_i,               // 20 MHz system clock
    input wire logic reset_n_i,               // sync reset, active low
    input wire logic [ADDR_W-1:0] io_addr_i,  // i/o port number
    input wire logic io_rd_i,                 // read strobe
    input wire logic io_wr_i,                 // write strobe
    input wire logic [7:0] io_wdata_i,        // write byte
    output logic [7:0] io_rdata_o,            // read byte, next cycle
    input wire logic [15:0] irq_i,            // request lines 0..15
    input wire logic inta_i,                  // acknowledge pulse
    input wire logic [7:0] primary_ack_i,     // primary line acknowledges
    output logic int_o,                       // secondary request out
    output logic [7:0] vector_o,              // vector of last acknowledge
    output logic [7:0] primary_req_o          // latched lines 0..7
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        pic_pkg::init_e init;
        logic sel_isr;
        logic need_mode;
        logic single;
        logic [7:0] mask;
        logic [7:0] in_service_reg;
        logic [4:0] vec_base;
        logic [7:0] ptm;
        logic [7:0] stm;
        logic [7:0] rdata;
        logic int_out;
        logic [7:0] vector;
        logic [7:0] pri_req;
    } pic_s;

    pic_s s;
    pic_s next_s;
    logic [15:0] line_req;
    logic [7:0] sec_ack;
    logic [7:0] sec_pending;
    logic [3:0] pend_pick;
    logic [3:0] serv_pick;
    logic sel_q;
    logic [7:0] isr_q;
    logic [7:0] mask_q;

    if (ADDR_W < 11)
    begin : g_check
        $error("port number too narrow for trigger-mode ports");
    end

    // highest-priority set bit, bit 0 first; msb flags a hit
    function automatic logic [3:0] pick(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    // port number compare at full width
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] p);
        return a == ADDR_W'(p);
    endfunction

    // ************************************************************
    // request latches
    // ************************************************************
    line_sense #(
        .LINES(16)
    ) u_sense (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .line_i(irq_i),
        .level_i({s.stm, s.ptm}),
        .ack_i({sec_ack, primary_ack_i}),
        .req_o(line_req)
    );

    // pending view and priority picks
    assign sec_pending = line_req[15:8];
    assign pend_pick = pick(sec_pending & ~s.mask);
    assign serv_pick = pick(s.in_service_reg);
    assign sel_q = s.sel_isr;
    assign isr_q = s.in_service_reg;
    assign mask_q = s.mask;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        next_s = s;
        sec_ack = 8'h00;
        next_s.pri_req = line_req[7:0];
        // writes
        if (io_wr_i)
        begin
            if (hit(io_addr_i, pic_pkg::PORT_CMD_STATUS))
            begin
                if (io_wdata_i[pic_pkg::INIT_BIT])
                begin
                    next_s.init = pic_pkg::INIT_VEC;
                    next_s.need_mode = io_wdata_i[pic_pkg::INIT_MODE_BIT];
                    next_s.single = io_wdata_i[pic_pkg::INIT_SINGLE_BIT];
                    next_s.mask = pic_pkg::MASK_RESET;
                    next_s.in_service_reg = pic_pkg::ISR_RESET;
                    next_s.sel_isr = 1'b0;
                end
                else if (io_wdata_i[4:3] == pic_pkg::OP_SEL_CODE)
                begin
                    if (io_wdata_i[pic_pkg::SEL_VALID_BIT])
                    begin
                        next_s.sel_isr = io_wdata_i[pic_pkg::SEL_ISR_BIT];
                    end
                end
                else if (io_wdata_i[4:3] == pic_pkg::OP_EOI_CODE)
                begin
                    if (io_wdata_i[7:5] == pic_pkg::EOI_NONSPEC && serv_pick[3])
                    begin
                        next_s.in_service_reg[serv_pick[2:0]] = 1'b0;
                    end
                    else if (io_wdata_i[7:5] == pic_pkg::EOI_SPEC)
                    begin
                        next_s.in_service_reg[io_wdata_i[2:0]] = 1'b0;
                    end
                end
            end
            else if (hit(io_addr_i, pic_pkg::PORT_LINE_MASK))
            begin
                case (s.init)
                    pic_pkg::INIT_VEC:
                    begin
                        next_s.vec_base = io_wdata_i[7:3];
                        if (!s.single)
                        begin
                            next_s.init = pic_pkg::INIT_CAS;
                        end
                        else if (s.need_mode)
                        begin
                            next_s.init = pic_pkg::INIT_MODE;
                        end
                        else
                        begin
                            next_s.init = pic_pkg::INIT_RUN;
                        end
                    end
                    pic_pkg::INIT_CAS:
                    begin
                        next_s.init = s.need_mode ? pic_pkg::INIT_MODE : pic_pkg::INIT_RUN;
                    end
                    pic_pkg::INIT_MODE:
                    begin
                        next_s.init = pic_pkg::INIT_RUN;
                    end
                    default:
                    begin
                        next_s.mask = io_wdata_i;
                    end
                endcase
            end
            else if (hit(io_addr_i, pic_pkg::PORT_PRI_TRIG))
            begin
                next_s.ptm = (io_wdata_i & ~pic_pkg::PRI_TRIG_FIXED)
                    | (s.ptm & pic_pkg::PRI_TRIG_FIXED);
            end
            else if (hit(io_addr_i, pic_pkg::PORT_SEC_TRIG))
            begin
                next_s.stm = (io_wdata_i & ~pic_pkg::SEC_TRIG_FIXED)
                    | (s.stm & pic_pkg::SEC_TRIG_FIXED);
            end
        end
        // acknowledge moves the top unmasked pending line into service
        if (inta_i && pend_pick[3])
        begin
            next_s.in_service_reg[pend_pick[2:0]] = 1'b1;
            sec_ack[pend_pick[2:0]] = 1'b1;
            next_s.vector = {s.vec_base, pend_pick[2:0]};
        end
        // request out when an unmasked line outranks all in service
        next_s.int_out = pend_pick[3] && (!serv_pick[3] || pend_pick[2:0] < serv_pick[2:0]);
        // reads; the selection is left untouched
        if (io_rd_i)
        begin
            if (hit(io_addr_i, pic_pkg::PORT_CMD_STATUS))
            begin
                next_s.rdata = s.sel_isr ? s.in_service_reg : sec_pending;
            end
            else if (hit(io_addr_i, pic_pkg::PORT_LINE_MASK))
            begin
                next_s.rdata = s.mask;
            end
            else if (hit(io_addr_i, pic_pkg::PORT_PRI_TRIG))
            begin
                next_s.rdata = s.ptm;
            end
            else if (hit(io_addr_i, pic_pkg::PORT_SEC_TRIG))
            begin
                next_s.rdata = s.stm;
            end
            else
            begin
                next_s.rdata = pic_pkg::UNMAPPED_READ;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            s.init <= pic_pkg::INIT_RUN;
            s.sel_isr <= 1'b0;
            s.need_mode <= 1'b0;
            s.single <= 1'b1;
            s.mask <= pic_pkg::MASK_RESET;
            s.in_service_reg <= pic_pkg::ISR_RESET;
            s.vec_base <= pic_pkg::VEC_BASE_RESET;
            s.ptm <= pic_pkg::TRIG_RESET;
            s.stm <= pic_pkg::TRIG_RESET;
            s.rdata <= 8'h00;
            s.int_out <= 1'b0;
            s.vector <= 8'h00;
            s.pri_req <= 8'h00;
        end
        else
        begin
            s <= next_s;
        end
    end

    // outputs straight from state
    assign io_rdata_o = s.rdata;
    assign int_o = s.int_out;
    assign vector_o = s.vector;
    assign primary_req_o = s.pri_req;

    // ************************************************************
    // checks
    // ************************************************************
    property p_status_read;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (io_rd_i && !io_wr_i && hit(io_addr_i, pic_pkg::PORT_CMD_STATUS))
        |=> io_rdata_o == ($past(sel_q) ? $past(isr_q) : $past(sec_pending));
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read returned wrong view");

    property p_sel_isr;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (io_wr_i && hit(io_addr_i, pic_pkg::PORT_CMD_STATUS) && io_wdata_i == 8'h0B)
        |=> sel_q;
    endproperty
    a_sel_isr: assert property (p_sel_isr)
        else $error("0Bh did not select in-service view");

    property p_sel_pending;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (io_wr_i && hit(io_addr_i, pic_pkg::PORT_CMD_STATUS) && io_wdata_i == 8'h0A)
        |=> !sel_q;
    endproperty
    a_sel_pending: assert property (p_sel_pending)
        else $error("0Ah did not select pending view");

    property p_sel_kept;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (io_rd_i && !io_wr_i) |=> $stable(sel_q);
    endproperty
    a_sel_kept: assert property (p_sel_kept)
        else $error("read changed the view selection");

    property p_init_word;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (io_wr_i && hit(io_addr_i, pic_pkg::PORT_CMD_STATUS) && io_wdata_i[4])
        |=> s.init == pic_pkg::INIT_VEC && mask_q == 8'h00;
    endproperty
    a_init_word: assert property (p_init_word)
        else $error("init word did not start initialisation");

    property p_mask_blocks;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        int_o |-> ($past(sec_pending) & ~$past(mask_q)) != 8'h00;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("request raised from blocked line");

    property p_pri_write;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (io_wr_i && hit(io_addr_i, pic_pkg::PORT_PRI_TRIG))
        |=> s.ptm[7:3] == $past(io_wdata_i[7:3]);
    endproperty
    a_pri_write: assert property (p_pri_write)
        else $error("primary trigger bits not written");

    property p_pri_fixed;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        1'b1 |=> $stable(s.ptm[2:0]);
    endproperty
    a_pri_fixed: assert property (p_pri_fixed)
        else $error("primary fixed trigger bits changed");

    property p_sec_write;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        (io_wr_i && hit(io_addr_i, pic_pkg::PORT_SEC_TRIG))
        |=> {s.stm[7:6], s.stm[4:1]} == {$past(io_wdata_i[7:6]), $past(io_wdata_i[4:1])};
    endproperty
    a_sec_write: assert property (p_sec_write)
        else $error("secondary trigger bits not written");

    property p_sec_fixed;
        @(posedge ref_clk_i) disable iff (!reset_n_i)
        1'b1 |=> $stable(s.stm[5]) && $stable(s.stm[0]);
    endproperty
    a_sec_fixed: assert property (p_sec_fixed)
        else $error("secondary fixed trigger bits changed");

endmodule

// >>> sim/test_slave_pic_regs.sv
// testbench: drives the secondary controller ports and judges read-back.
// assumes pic_pkg and slave_pic_regs compiled first, 20 MHz clock.
`timescale 1ns/10ps
`define CHECK(what, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
        end \
    end
module test_slave_pic_regs;
    logic ref_clk_i;
    logic reset_n_i;
    logic [15:0] io_addr_i;
    logic io_rd_i;
    logic io_wr_i;
    logic [7:0] io_wdata_i;
    logic [7:0] io_rdata_o;
    logic [15:0] irq_i;
    logic inta_i;
    logic [7:0] primary_ack_i;
    logic int_o;
    logic [7:0] vector_o;
    logic [7:0] primary_req_o;
    int bad_count = 0;
    int n_checks = 0;

    // ************************************************************
    // clock, device and watchdog
    // ************************************************************
    initial
    begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    slave_pic_regs #(.ADDR_W(16)) dut (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .io_addr_i(io_addr_i),
        .io_rd_i(io_rd_i),
        .io_wr_i(io_wr_i),
        .io_wdata_i(io_wdata_i),
        .io_rdata_o(io_rdata_o),
        .irq_i(irq_i),
        .inta_i(inta_i),
        .primary_ack_i(primary_ack_i),
        .int_o(int_o),
        .vector_o(vector_o),
        .primary_req_o(primary_req_o)
    );

    // about 190 cycles expected, cut off at 20000
    initial
    begin
        #1000000;
        bad_count++;
        finish_test();
    end

    // ************************************************************
    // bus and line helpers, all driven at the falling edge
    // ************************************************************
    task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
        @(negedge ref_clk_i);
        io_addr_i = addr;
        io_wdata_i = data;
        io_wr_i = 1'b1;
        @(negedge ref_clk_i);
        io_wr_i = 1'b0;
    endtask

    // read byte is registered at the read edge, looked at one cycle on
    task automatic check_read(input logic [15:0] addr, input logic [7:0] exp,
                              input string what);
        @(negedge ref_clk_i);
        io_addr_i = addr;
        io_rd_i = 1'b1;
        @(negedge ref_clk_i);
        io_rd_i = 1'b0;
        @(negedge ref_clk_i);
        `CHECK(what, exp, io_rdata_o)
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // bounded wait for the request output to reach a level
    task automatic wait_int(input logic exp, input string what);
        int i;
        for (i = 0; i < 8 && int_o !== exp; i++)
            @(negedge ref_clk_i);
        `CHECK(what, exp, int_o)
    endtask

    task automatic pulse_inta;
        @(negedge ref_clk_i);
        inta_i = 1'b1;
        @(negedge ref_clk_i);
        inta_i = 1'b0;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic reset_values;
        check_read(pic_pkg::PORT_PRI_TRIG, 8'h00, "pri trig reset");
        check_read(pic_pkg::PORT_SEC_TRIG, 8'h00, "sec trig reset");
        check_read(pic_pkg::PORT_CMD_STATUS, 8'h00, "pending reset");
        check_read(pic_pkg::PORT_LINE_MASK, 8'h00, "mask reset");
    endtask

    // fixed trigger bits ignore writes, others follow
    task automatic trigger_fixed_bits;
        io_write(pic_pkg::PORT_PRI_TRIG, 8'hFF);
        check_read(pic_pkg::PORT_PRI_TRIG, 8'hF8, "pri trig ones");
        io_write(pic_pkg::PORT_PRI_TRIG, 8'h00);
        check_read(pic_pkg::PORT_PRI_TRIG, 8'h00, "pri trig zeros");
        io_write(pic_pkg::PORT_SEC_TRIG, 8'hFF);
        check_read(pic_pkg::PORT_SEC_TRIG, 8'hDE, "sec trig ones");
        io_write(pic_pkg::PORT_SEC_TRIG, 8'h00);
        check_read(pic_pkg::PORT_SEC_TRIG, 8'h00, "sec trig zeros");
        check_read(16'h00A2, pic_pkg::UNMAPPED_READ, "unmapped read");
    endtask

    // view selection sticks over repeated reads
    task automatic view_select;
        @(negedge ref_clk_i);
        irq_i[9] = 1'b1;
        idle(3);
        check_read(pic_pkg::PORT_CMD_STATUS, 8'h02, "pending line 9");
        io_write(pic_pkg::PORT_CMD_STATUS, 8'h0B);
        check_read(pic_pkg::PORT_CMD_STATUS, 8'h00, "service empty");
        check_read(pic_pkg::PORT_CMD_STATUS, 8'h00, "service again");
        wait_int(1'b1, "int raised line 9");
        pulse_inta();
        check_read(pic_pkg::PORT_CMD_STATUS, 8'h02, "service line 9");
        check_read(pic_pkg::PORT_CMD_STATUS, 8'h02, "service repeat");
        `CHECK("vector line 9", 8'h01, vector_o)
        io_write(pic_pkg::PORT_CMD_STATUS, 8'h0A);
        check_read(pic_pkg::PORT_CMD_STATUS, 8'h00, "edge latch cleared");
        io_write(pic_pkg::PORT_CMD_STATUS, 8'h20);
        io_write(pic_pkg::PORT_CMD_STATUS, 8'h0B);
        check_read(pic_pkg::PORT_CMD_STATUS, 8'h00, "end of service");
        io_write(pic_pkg::PORT_CMD_STATUS, 8'h0A);
        @(negedge ref_clk_i);
        irq_i[9] = 1'b0;
    endtask

    // blocked line stays pending but silent until let through
    task automatic mask_line;
        io_write(pic_pkg::PORT_LINE_MASK, 8'h02);
        check_read(pic_pkg::PORT_LINE_MASK, 8'h02, "mask readback");
        @(negedge ref_clk_i);
        irq_i[9] = 1'b1;
        idle(5);
        `CHECK("int blocked", 1'b0, int_o)
        check_read(pic_pkg::PORT_CMD_STATUS, 8'h02, "masked pending");
        io_write(pic_pkg::PORT_LINE_MASK, 8'h00);
        wait_int(1'b1, "int unblocked");
        pulse_inta();
        io_write(pic_pkg::PORT_CMD_STATUS, 8'h20);
        irq_i[9] = 1'b0;
        idle(3);
        `CHECK("int quiet", 1'b0, int_o)
    endtask

    // level line follows input, edge line keeps its latch
    task automatic sense_modes;
        check_read(pic_pkg::PORT_SEC_TRIG, 8'h00, "sec trig before change");
        // fixed bits written back as read, only line 10 altered
        io_write(pic_pkg::PORT_SEC_TRIG, 8'h04);
        check_read(pic_pkg::PORT_SEC_TRIG, 8'h04, "line 10 level");
        @(negedge ref_clk_i);
        irq_i[11:10] = 2'b11;
        idle(3);
        check_read(pic_pkg::PORT_CMD_STATUS, 8'h0C, "both high");
        @(negedge ref_clk_i);
        irq_i[11:10] = 2'b00;
        idle(3);
        check_read(pic_pkg::PORT_CMD_STATUS, 8'h08, "level dropped");
    endtask

    // init sequence: base, mode word, mask; leftover line 11 then served
    task automatic init_sequence;
        io_write(pic_pkg::PORT_CMD_STATUS, 8'h13);
        io_write(pic_pkg::PORT_LINE_MASK, 8'h48);
        io_write(pic_pkg::PORT_LINE_MASK, 8'h01);
        io_write(pic_pkg::PORT_LINE_MASK, 8'h00);
        check_read(pic_pkg::PORT_LINE_MASK, 8'h00, "mask after init");
        check_read(pic_pkg::PORT_SEC_TRIG, 8'h04, "trig kept");
        wait_int(1'b1, "int line 11");
        pulse_inta();
        `CHECK("vector with base", 8'h4B, vector_o)
        // specific end of service on line 11
        io_write(pic_pkg::PORT_CMD_STATUS, 8'h0B);
        check_read(pic_pkg::PORT_CMD_STATUS, 8'h08, "service line 11");
        io_write(pic_pkg::PORT_CMD_STATUS, 8'h63);
        check_read(pic_pkg::PORT_CMD_STATUS, 8'h00, "specific end");
        // re-init with cascade word and no mode word
        io_write(pic_pkg::PORT_CMD_STATUS, 8'h10);
        io_write(pic_pkg::PORT_LINE_MASK, 8'h50);
        io_write(pic_pkg::PORT_LINE_MASK, 8'h02);
        check_read(pic_pkg::PORT_LINE_MASK, 8'h00, "cascade word not mask");
        io_write(pic_pkg::PORT_LINE_MASK, 8'hFF);
        check_read(pic_pkg::PORT_LINE_MASK, 8'hFF, "mask all");
    endtask

    // primary line edge latch and its acknowledge
    task automatic primary_line;
        @(negedge ref_clk_i);
        irq_i[3] = 1'b1;
        idle(3);
        `CHECK("primary latched", 8'h08, primary_req_o)
        @(negedge ref_clk_i);
        primary_ack_i = 8'h08;
        @(negedge ref_clk_i);
        primary_ack_i = 8'h00;
        idle(2);
        `CHECK("primary cleared", 8'h00, primary_req_o)
    endtask

    // ************************************************************
    // verdict and main sequence
    // ************************************************************
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        reset_n_i = 1'b0;
        io_addr_i = 16'h0000;
        io_rd_i = 1'b0;
        io_wr_i = 1'b0;
        io_wdata_i = 8'h00;
        irq_i = 16'h0000;
        inta_i = 1'b0;
        primary_ack_i = 8'h00;
        idle(20);
        reset_n_i = 1'b1;
        reset_values();
        trigger_fixed_bits();
        view_select();
        mask_line();
        sense_modes();
        init_sequence();
        primary_line();
        finish_test();
    end
endmodule
